// ### design/mlg_pkg.sv
// package: register offsets, field layouts, reset values and decoded setting types for the modem loop gain block
package mlg_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [5:0] BIT_SYNC_CONFIG_ADDR = 6'h1a;
    localparam logic [5:0] GAIN_CONTROL_2_ADDR  = 6'h1b;

    localparam logic [7:0] BIT_SYNC_CONFIG_RST  = 8'h6c;
    localparam logic [7:0] GAIN_CONTROL_2_RST   = 8'h03;

    // ****************************************
    // field positions
    // ****************************************
    localparam int PRE_KI_LSB  = 6;
    localparam int PRE_KP_LSB  = 4;
    localparam int POST_KI_BIT = 3;
    localparam int POST_KP_BIT = 2;
    localparam int LIMIT_LSB   = 0;
    localparam int DIGITAL_VARIABLE_AMP_LSB    = 6;
    localparam int LNA_LSB     = 3;
    localparam int TARGET_LSB  = 0;

    // amplitude targets in dB, indexed by setting code
    localparam logic [5:0] TARGET_DB_0 = 6'h18;
    localparam logic [5:0] TARGET_DB_1 = 6'h1b;
    localparam logic [5:0] TARGET_DB_2 = 6'h1e;
    localparam logic [5:0] TARGET_DB_3 = 6'h21;
    localparam logic [5:0] TARGET_DB_4 = 6'h24;
    localparam logic [5:0] TARGET_DB_5 = 6'h26;
    localparam logic [5:0] TARGET_DB_6 = 6'h28;
    localparam logic [5:0] TARGET_DB_7 = 6'h2a;

    // front-end cap reductions in tenths of a dB, indexed by setting code
    localparam logic [7:0] LNA_CUT_0 = 8'h00;
    localparam logic [7:0] LNA_CUT_1 = 8'h1a;
    localparam logic [7:0] LNA_CUT_2 = 8'h3d;
    localparam logic [7:0] LNA_CUT_3 = 8'h4a;
    localparam logic [7:0] LNA_CUT_4 = 8'h5c;
    localparam logic [7:0] LNA_CUT_5 = 8'h73;
    localparam logic [7:0] LNA_CUT_6 = 8'h92;
    localparam logic [7:0] LNA_CUT_7 = 8'hab;

    // rate saturation limits in thousandths of a percent
    localparam logic [13:0] RATE_LIMIT_1 = 14'h0c35;
    localparam logic [13:0] RATE_LIMIT_2 = 14'h186a;
    localparam logic [13:0] RATE_LIMIT_3 = 14'h30d4;
    localparam logic [13:0] RATE_LIMIT_0 = 14'h0000;

    // ****************************************
    // carriers
    // ****************************************
    // gains are expressed in half-steps of the base gain: 2 = 1x, 1 = 0.5x
    typedef struct packed {
        logic [3:0]  integral_half_steps;
        logic [3:0]  proportional_half_steps;
        logic        rate_comp_enable;
        logic [13:0] rate_limit_milli_pct;
    } mlg_clock_loop_t;

    typedef struct packed {
        logic [1:0] digital_amp_excluded;
        logic [7:0] front_amp_cut_tenth_db;
        logic [5:0] amplitude_target_db;
    } mlg_agc_t;

    typedef struct packed {
        logic       write;
        logic [5:0] addr;
        logic [7:0] wdata;
    } mlg_reg_req_t;

endpackage

// ### design/mlg_gain_decode.sv
// gain control decode: amplifier caps and amplitude target from the gain control register
module mlg_gain_decode
    import mlg_pkg::*;
(
    input  wire logic [7:0]   i_gain_control_2,
    output mlg_pkg::mlg_agc_t o_agc
);

    logic [1:0] digital_variable_amp_field;
    logic [2:0] lna_field;
    logic [2:0] target_field;

    assign digital_variable_amp_field   = i_gain_control_2[DIGITAL_VARIABLE_AMP_LSB +: 2];
    assign lna_field    = i_gain_control_2[LNA_LSB +: 3];
    assign target_field = i_gain_control_2[TARGET_LSB +: 3];

    always_comb begin
        o_agc.digital_amp_excluded = digital_variable_amp_field;
        unique case (lna_field)
            3'h0: o_agc.front_amp_cut_tenth_db = LNA_CUT_0;
            3'h1: o_agc.front_amp_cut_tenth_db = LNA_CUT_1;
            3'h2: o_agc.front_amp_cut_tenth_db = LNA_CUT_2;
            3'h3: o_agc.front_amp_cut_tenth_db = LNA_CUT_3;
            3'h4: o_agc.front_amp_cut_tenth_db = LNA_CUT_4;
            3'h5: o_agc.front_amp_cut_tenth_db = LNA_CUT_5;
            3'h6: o_agc.front_amp_cut_tenth_db = LNA_CUT_6;
            3'h7: o_agc.front_amp_cut_tenth_db = LNA_CUT_7;
        endcase
        unique case (target_field)
            3'h0: o_agc.amplitude_target_db = TARGET_DB_0;
            3'h1: o_agc.amplitude_target_db = TARGET_DB_1;
            3'h2: o_agc.amplitude_target_db = TARGET_DB_2;
            3'h3: o_agc.amplitude_target_db = TARGET_DB_3;
            3'h4: o_agc.amplitude_target_db = TARGET_DB_4;
            3'h5: o_agc.amplitude_target_db = TARGET_DB_5;
            3'h6: o_agc.amplitude_target_db = TARGET_DB_6;
            3'h7: o_agc.amplitude_target_db = TARGET_DB_7;
        endcase
    end

endmodule

// ### design/mlg_loop_config.sv
// modem loop gain configuration: register pair, sync phase tracking and decoded loop settings
module mlg_loop_config
    import mlg_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_n,
    input  wire mlg_pkg::mlg_reg_req_t i_req,
    input  wire logic                  i_req_valid,
    input  wire logic                  i_rx_start,
    input  wire logic                  i_sync_found,
    output logic [7:0]                 o_rdata,
    output logic                       o_post_sync,
    output mlg_pkg::mlg_clock_loop_t   o_clock_loop,
    output mlg_pkg::mlg_agc_t          o_agc
);

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] bit_sync_config_q;
    logic [7:0] bit_sync_config_d;
    logic [7:0] gain_control_2_q;
    logic [7:0] gain_control_2_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       post_sync_q;
    logic       post_sync_d;

    always_comb begin
        bit_sync_config_d = bit_sync_config_q;
        gain_control_2_d  = gain_control_2_q;
        rdata_d           = 8'h00;
        if (i_req_valid && i_req.write) begin
            if (i_req.addr == BIT_SYNC_CONFIG_ADDR) begin
                bit_sync_config_d = i_req.wdata;
            end
            if (i_req.addr == GAIN_CONTROL_2_ADDR) begin
                gain_control_2_d = i_req.wdata;
            end
        end
        // unmapped addresses read as zero
        if (i_req.addr == BIT_SYNC_CONFIG_ADDR) begin
            rdata_d = bit_sync_config_q;
        end else if (i_req.addr == GAIN_CONTROL_2_ADDR) begin
            rdata_d = gain_control_2_q;
        end
    end

    // ****************************************
    // sync phase
    // ****************************************
    // a new reception outranks a sync hit in the same cycle: stale sync must not carry over
    always_comb begin
        post_sync_d = post_sync_q;
        if (i_rx_start) begin
            post_sync_d = 1'b0;
        end else if (i_sync_found) begin
            post_sync_d = 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_sync_config_q <= BIT_SYNC_CONFIG_RST;
            gain_control_2_q  <= GAIN_CONTROL_2_RST;
            rdata_q           <= 8'h00;
            post_sync_q       <= 1'b0;
        end else begin
            bit_sync_config_q <= bit_sync_config_d;
            gain_control_2_q  <= gain_control_2_d;
            rdata_q           <= rdata_d;
            post_sync_q       <= post_sync_d;
        end
    end

    assign o_rdata     = rdata_q;
    assign o_post_sync = post_sync_q;

    // ****************************************
    // clock recovery decode
    // ****************************************
    // code n gives (n+1) times base, i.e. 2(n+1) half-steps
    function automatic logic [3:0] gain_half_steps(input logic [1:0] code);
        return {1'b0, code, 1'b0} + 4'h2;
    endfunction

    logic [1:0] pre_ki;
    logic [1:0] pre_kp;
    logic       post_ki;
    logic       post_kp;
    logic [1:0] limit_code;

    assign pre_ki     = bit_sync_config_q[PRE_KI_LSB +: 2];
    assign pre_kp     = bit_sync_config_q[PRE_KP_LSB +: 2];
    assign post_ki    = bit_sync_config_q[POST_KI_BIT];
    assign post_kp    = bit_sync_config_q[POST_KP_BIT];
    assign limit_code = bit_sync_config_q[LIMIT_LSB +: 2];

    always_comb begin
        o_clock_loop.integral_half_steps     = gain_half_steps(pre_ki);
        o_clock_loop.proportional_half_steps = gain_half_steps(pre_kp);
        if (post_sync_q && post_ki) begin
            o_clock_loop.integral_half_steps = 4'h1;
        end
        if (post_sync_q && post_kp) begin
            o_clock_loop.proportional_half_steps = 4'h2;
        end
        o_clock_loop.rate_comp_enable = (limit_code != 2'h0);
        unique case (limit_code)
            2'h0: o_clock_loop.rate_limit_milli_pct = RATE_LIMIT_0;
            2'h1: o_clock_loop.rate_limit_milli_pct = RATE_LIMIT_1;
            2'h2: o_clock_loop.rate_limit_milli_pct = RATE_LIMIT_2;
            2'h3: o_clock_loop.rate_limit_milli_pct = RATE_LIMIT_3;
        endcase
    end

    // ****************************************
    // gain control decode
    // ****************************************
    mlg_gain_decode u_gain_decode (
        .i_gain_control_2 (gain_control_2_q),
        .o_agc            (o_agc)
    );

endmodule

// ### verification/mlg_loop_config_asserts.sv
// assertion checker for the modem loop gain configuration block
module mlg_loop_config_asserts (
    input wire logic                     i_clock,
    input wire logic                     i_rst_n,
    input wire mlg_pkg::mlg_reg_req_t    i_req,
    input wire logic                     i_req_valid,
    input wire logic                     i_rx_start,
    input wire logic                     i_sync_found,
    input wire logic [7:0]               o_rdata,
    input wire logic                     o_post_sync,
    input wire mlg_pkg::mlg_clock_loop_t o_clock_loop,
    input wire mlg_pkg::mlg_agc_t        o_agc
);
    import mlg_pkg::*;
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic wr_bs;
    logic wr_gc;
    assign wr_bs = i_req_valid && i_req.write && i_req.addr == BIT_SYNC_CONFIG_ADDR;
    assign wr_gc = i_req_valid && i_req.write && i_req.addr == GAIN_CONTROL_2_ADDR;
    sync_enter_a: assert property (i_sync_found && !i_rx_start |=> o_post_sync)
        else $error("sync did not select post gains");
    rx_clear_a: assert property (i_rx_start |=> !o_post_sync)
        else $error("new reception kept post gains");
    pre_gain_a: assert property (wr_bs && i_rx_start |=>
        o_clock_loop.integral_half_steps == {1'b0, $past(i_req.wdata[7:6]), 1'b0} + 4'h2 &&
        o_clock_loop.proportional_half_steps == {1'b0, $past(i_req.wdata[5:4]), 1'b0} + 4'h2)
        else $error("pre sync gains wrong");
    post_gain_a: assert property (wr_bs && i_sync_found && !i_rx_start && i_req.wdata[3:2] == 2'h3 |=>
        o_clock_loop.integral_half_steps == 4'h1 && o_clock_loop.proportional_half_steps == 4'h2)
        else $error("post sync gains wrong");
    rate_limit_a: assert property (wr_bs && i_req.wdata[1:0] == 2'h3 |=> o_clock_loop.rate_limit_milli_pct == 14'h30d4)
        else $error("rate limit wrong");
    rate_off_a: assert property (wr_bs && i_req.wdata[1:0] == 2'h0 |=> !o_clock_loop.rate_comp_enable)
        else $error("rate compensation left on");
    amp_excl_a: assert property (wr_gc |=> o_agc.digital_amp_excluded == $past(i_req.wdata[7:6]))
        else $error("excluded amplifier settings wrong");
    front_cap_a: assert property (wr_gc && i_req.wdata[5:3] == 3'h7 |=> o_agc.front_amp_cut_tenth_db == 8'hab)
        else $error("front amplifier cap wrong");
    amp_target_a: assert property (wr_gc && i_req.wdata[2:0] == 3'h7 |=> o_agc.amplitude_target_db == 6'h2a)
        else $error("amplitude target wrong");
    cover property (i_sync_found && !i_rx_start);
    cover property (i_rx_start && i_sync_found);
    cover property (wr_gc);
endmodule

// ### verification/mlg_loop_config_bench.sv
// self-checking bench for the modem loop gain configuration block
module mlg_loop_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mlg_pkg::*;
    logic            i_clock      = 1'b0;
    logic            i_rst_n      = 1'b0;
    mlg_reg_req_t    i_req        = '0;
    logic            i_req_valid  = 1'b0;
    logic            i_rx_start   = 1'b0;
    logic            i_sync_found = 1'b0;
    logic [7:0]      o_rdata;
    logic            o_post_sync;
    mlg_clock_loop_t o_clock_loop;
    mlg_agc_t        o_agc;
    logic [47:0]     exp_q[$];
    logic [7:0]      bs = 8'h6c;
    logic [7:0]      gc = 8'h03;
    logic            post = 1'b0;
    logic            chk = 1'b0;
    logic [31:0]     seed = 32'h94eb99cb;
    int              bad_count = 0;
    int              check_count = 0;
    always #20 i_clock = ~i_clock;
    mlg_loop_config DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(i_req), .i_req_valid(i_req_valid),
        .i_rx_start(i_rx_start), .i_sync_found(i_sync_found), .o_rdata(o_rdata), .o_post_sync(o_post_sync),
        .o_clock_loop(o_clock_loop), .o_agc(o_agc));
    // ****************************************
    // reference model and driver
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [47:0] model(input logic [7:0] rd);
        logic [3:0]  ki;
        logic [3:0]  kp;
        logic [13:0] lim [4];
        logic [7:0]  cut [8];
        logic [5:0]  tg [8];
        lim = '{14'h0000, 14'h0c35, 14'h186a, 14'h30d4};
        cut = '{8'h00, 8'h1a, 8'h3d, 8'h4a, 8'h5c, 8'h73, 8'h92, 8'hab};
        tg = '{6'h18, 6'h1b, 6'h1e, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2a};
        ki = {1'b0, bs[7:6], 1'b0} + 4'h2;
        kp = {1'b0, bs[5:4], 1'b0} + 4'h2;
        if (post && bs[3]) ki = 4'h1;
        if (post && bs[2]) kp = 4'h2;
        return {rd, post, ki, kp, bs[1:0] != 2'h0, lim[bs[1:0]], gc[7:6], cut[gc[5:3]], tg[gc[2:0]]};
    endfunction
    task automatic cyc(input logic v, w, input logic [5:0] a, input logic [7:0] d, input logic rx, sy);
        logic [7:0] rd;
        @(negedge i_clock);
        i_req_valid = v;
        i_req = '{w, a, d};
        i_rx_start = rx;
        i_sync_found = sy;
        // a read in the cycle of a write still returns the old contents
        rd = (a == 6'h1a) ? bs : (a == 6'h1b) ? gc : 8'h00;
        if (v && w && a == 6'h1a) bs = d;
        if (v && w && a == 6'h1b) gc = d;
        post = rx ? 1'b0 : (sy ? 1'b1 : post);
        exp_q.push_back(model(rd));
        chk = 1'b1;
    endtask
    // a mid-run reset must bring back every reset value, whatever was written before
    task automatic reset_pulse();
        @(negedge i_clock);
        i_rst_n = 1'b0;
        i_req_valid = 1'b0;
        i_req = '0;
        i_rx_start = 1'b0;
        i_sync_found = 1'b0;
        bs = 8'h6c;
        gc = 8'h03;
        post = 1'b0;
        exp_q.push_back(model(8'h00));
        @(negedge i_clock);
        i_rst_n = 1'b1;
        exp_q.push_back(model(8'h00));
    endtask
    task automatic check(input logic [47:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge i_clock) begin
        if (chk) begin
            #1 check({o_rdata, o_post_sync, o_clock_loop, o_agc}, exp_q.pop_front());
        end
    end
    // ****************************************
    // stimulus
    // ****************************************
    initial begin
        repeat (3) @(negedge i_clock);
        i_rst_n = 1'b1;
        cyc(0, 0, 6'h1a, 8'h00, 0, 0);
        cyc(0, 0, 6'h1b, 8'h00, 0, 0);
        cyc(1, 1, 6'h1a, 8'h0f, 1, 0);
        cyc(1, 1, 6'h1a, 8'h0c, 0, 1);
        cyc(1, 1, 6'h1b, 8'hff, 1, 1);
        for (int n = 0; n < 300; n++) begin
            if (n == 150) begin
                reset_pulse();
            end
            seed = xs(seed);
            cyc(seed[0], seed[1], seed[8] ? {5'h0d, seed[9]} : seed[7:2], seed[23:16],
                seed[12:10] == 3'h0, seed[15:13] == 3'h0);
        end
        @(posedge i_clock);
        #2 complete_run();
    end
    initial begin
        #(40 * 1000);
        bad_count++;
        complete_run();
    end
endmodule
bind mlg_loop_config mlg_loop_config_asserts u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(i_req),
    .i_req_valid(i_req_valid), .i_rx_start(i_rx_start), .i_sync_found(i_sync_found), .o_rdata(o_rdata),
    .o_post_sync(o_post_sync), .o_clock_loop(o_clock_loop), .o_agc(o_agc));
